// ---- src/tsr_repacker.sv ----
// What this block does
// - whole-packet output length selectable as 188, 204 or 208 bytes
// - pad or trim dummy correction bytes after the 188-byte payload
// - packet bytes go back to back; fill symbols only between packets
// - immediate-forward mode sends each input byte as soon as ready
// - fill symbols whenever no byte is waiting to be sent
// - immediate-forward keeps input byte timing and packet length unchanged
// - input rate setting picks 19.39 or 38.78 Mbit/s; operator sets it
// - one rate setting serves this path and the reverse-path reference
// - per-indicator asserted polarity, high after reset, may be low
// - enable mask decides which conditions reach health and alarm reporting
// - flag serial input present but not decodable
// - flag sync input absent or its rate wrong for the setting
// - flag serial payload rate above sync output rate
// - flag no signal at the serial input
// - flag output jack switched to menu overlay video
// - normal switch position routes converter output to jack, overlay off
// - count occurrences per assigned indicator, clearable by command
// - any enabled condition drives card health to error
`default_nettype none
module tsr_repacker
  import tsr_pkg::*;
#(
  parameter int WIN_CYC = tsr_pkg::RATE_WIN_CYC,
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // synchronous transport-stream input, same clock
  input wire tsr_pkg::tsr_ts_t ts_in,
  // asynchronous status pins
  input wire tsr_pkg::tsr_pins_t pins,
  // overlay video symbols, same clock
  input wire tsr_pkg::tsr_sym_t ovl_sym,
  // serial output and jack
  output tsr_pkg::tsr_sym_t conv_sym,
  output tsr_pkg::tsr_sym_t jack_sym,
  output logic overlay_active,
  // shared rate setting to the reverse path
  output logic ref_rate_hi,
  // health and indicators
  output logic card_err,
  output logic net_alarm,
  output logic [7:0] ind_out
);
  import tsr_pkg::*;

  // rate window limits; a tolerance of 1/16 absorbs the uneven spacing
  // of a paced source without letting the other rate pass
  localparam logic [15:0] WIN_LAST = 16'(WIN_CYC - 1);
  localparam int EXP_LO = RATE_LO_KBPS * WIN_CYC / (8 * CLK_KHZ);
  localparam int EXP_HI = RATE_HI_KBPS * WIN_CYC / (8 * CLK_KHZ);
  localparam logic [15:0] LO_MIN = 16'(EXP_LO - (EXP_LO >> RATE_TOL_SHIFT));
  localparam logic [15:0] LO_MAX = 16'(EXP_LO + (EXP_LO >> RATE_TOL_SHIFT));
  localparam logic [15:0] HI_MIN = 16'(EXP_HI - (EXP_HI >> RATE_TOL_SHIFT));
  localparam logic [15:0] HI_MAX = 16'(EXP_HI + (EXP_HI >> RATE_TOL_SHIFT));

  // all state except the packet memory lives in one struct so reset and update stay in two processes
  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
    logic [3:0] pin;
    tsr_mode_t mode;
    logic rate_hi;
    logic [4:0] en;
    logic [7:0][2:0] sel;
    logic [7:0] pol;
    logic [7:0] wr_cnt;
    logic wr_slot;
    logic wr_act;
    logic [1:0] rdy;
    logic rd_slot;
    tsr_tx_st_t tx_st;
    logic [7:0] tx_cnt;
    logic rd_pend;
    logic dum_pend;
    logic [15:0] win_cnt;
    logic [15:0] byte_cnt;
    logic sync_miss;
    logic [4:0] cond_prev;
    logic [7:0][CNT_W-1:0] cnt;
    tsr_sym_t tx;
    tsr_sym_t jack;
    logic ovl;
    logic card_err;
    logic [7:0] ind;
    logic [31:0] rdata;
  } tsr_state_t;

  tsr_state_t q;
  tsr_state_t d;
  // packet memory port, driven from the next-state logic
  logic mem_we;
  logic [8:0] mem_waddr;
  logic [7:0] mem_wdata;
  logic [8:0] mem_raddr;
  logic [7:0] mem_rdata;

  // condition picked by an indicator selector; out-of-range codes pick nothing
  function automatic logic tsr_pick(input logic [4:0] v, input logic [2:0] s);
    tsr_pick = (s < 3'(NCOND)) ? v[s] : 1'b0;
  endfunction

  // output length for a packet mode
  function automatic logic [7:0] tsr_len(input tsr_mode_t m);
    unique case (m)
      MODE_P204: tsr_len = LEN_204;
      MODE_P208: tsr_len = LEN_208;
      default: tsr_len = LEN_188;
    endcase
  endfunction

  // two packet slots so one fills while the other drains
  tsr_pkt_mem #(.AW(9), .DW(8)) u_mem (
    .ref_clk(ref_clk),
    .rst(rst),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr(mem_raddr),
    .rdata(mem_rdata)
  );

  // next-state logic for the whole block
  always_comb begin
    logic [4:0] cond;
    logic clr;
    logic [7:0] pos;
    logic act;
    logic [7:0] len;
    logic hit;
    logic ev;
    logic ok;
    cond = '0;
    clr = 1'b0;
    pos = '0;
    act = 1'b0;
    len = '0;
    hit = 1'b0;
    ev = 1'b0;
    ok = 1'b0;
    d = q;
    mem_we = 1'b0;
    mem_waddr = '0;
    mem_wdata = '0;
    mem_raddr = '0;

    // pin synchroniser: a change is taken once the second and third stages agree
    d.s1 = pins;
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < 4; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.pin[i] = q.s3[i];
      end
    end

    // register writes
    if (reg_wr) begin
      unique case (reg_addr)
        OFS_CTRL: begin
          d.mode = tsr_mode_t'(reg_wdata[CTRL_MODE_LSB +: 2]);
          d.rate_hi = reg_wdata[CTRL_RATE_BIT];
        end
        OFS_ALARM_EN: d.en = reg_wdata[4:0];
        OFS_IND_SEL: d.sel = reg_wdata[23:0];
        OFS_IND_POL: d.pol = reg_wdata[7:0];
        default: ;
      endcase
    end
    clr = reg_wr && (reg_addr == OFS_CNT_CLR) && reg_wdata[0];

    // reads answer one cycle later and drop back to zero after that
    d.rdata = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        OFS_CTRL: d.rdata = {29'h0, q.rate_hi, q.mode};
        OFS_ALARM_EN: d.rdata = {27'h0, q.en};
        OFS_IND_SEL: d.rdata = {8'h0, q.sel};
        OFS_IND_POL: d.rdata = {24'h0, q.pol};
        OFS_STATUS: d.rdata = {8'h0, q.ind, 7'h0, q.card_err, 3'h0, q.cond_prev};
        default: begin
          if (reg_addr[3]) begin
            d.rdata = 32'(q.cnt[reg_addr[2:0]]);
          end
        end
      endcase
    end

    // capture the 188-byte payload of each input packet into a free slot
    pos = ts_in.start ? 8'h00 : q.wr_cnt;
    act = ts_in.start ? ~q.rdy[q.wr_slot] : q.wr_act;
    if (ts_in.valid && q.mode != MODE_BYTE) begin
      d.wr_act = act;
      if (act && pos < PAY_LEN) begin
        mem_we = 1'b1;
        mem_waddr = {q.wr_slot, pos};
        mem_wdata = ts_in.data;
        d.wr_cnt = pos + 8'h01;
        if (pos == PAY_LEN - 8'h01) begin
          // trailing input correction bytes are dropped here
          d.rdy[q.wr_slot] = 1'b1;
          d.wr_slot = ~q.wr_slot;
          d.wr_act = 1'b0;
        end
      end
    end

    // output symbol: fill unless a byte is due
    d.tx = '{k: 1'b1, data: K28_5};
    d.rd_pend = 1'b0;
    d.dum_pend = 1'b0;
    if (q.mode == MODE_BYTE) begin
      // no slot is kept, so a late switch to byte mode drops the pending packet
      if (ts_in.valid) begin
        d.tx = '{k: 1'b0, data: ts_in.data};
      end
      d.rdy = '0;
      d.tx_st = TX_IDLE;
      d.wr_act = 1'b0;
    end else begin
      if (q.rd_pend) begin
        d.tx = '{k: 1'b0, data: mem_rdata};
      end else if (q.dum_pend) begin
        d.tx = '{k: 1'b0, data: DUMMY_BYTE};
      end
      len = tsr_len(q.mode);
      unique case (q.tx_st)
        TX_IDLE: begin
          // a packet starts only once all its payload is stored
          if (q.rdy[q.rd_slot]) begin
            d.tx_st = TX_SEND;
            d.tx_cnt = 8'h00;
          end
        end
        TX_SEND: begin
          // length follows the live mode, so a switch to a longer packet
          // stretches the one in flight instead of cutting it
          if (q.tx_cnt < PAY_LEN) begin
            mem_raddr = {q.rd_slot, q.tx_cnt};
            d.rd_pend = 1'b1;
          end else begin
            d.dum_pend = 1'b1;
          end
          if (q.tx_cnt == len - 8'h01) begin
            d.tx_st = TX_IDLE;
            d.rdy[q.rd_slot] = 1'b0;
            d.rd_slot = ~q.rd_slot;
          end else begin
            d.tx_cnt = q.tx_cnt + 8'h01;
          end
        end
      endcase
    end

    // overlay switch steers the shared jack
    d.ovl = q.pin[P_OVERLAY];
    d.jack = q.pin[P_OVERLAY] ? ovl_sym : q.tx;

    // input rate measurement over a fixed window
    if (q.win_cnt == WIN_LAST) begin
      d.win_cnt = 16'h0000;
      d.byte_cnt = {15'h0, ts_in.valid};
      ok = q.rate_hi ? (q.byte_cnt >= HI_MIN && q.byte_cnt <= HI_MAX)
                     : (q.byte_cnt >= LO_MIN && q.byte_cnt <= LO_MAX);
      d.sync_miss = ~ok;
    end else begin
      d.win_cnt = q.win_cnt + 16'h0001;
      if (ts_in.valid && q.byte_cnt != 16'hffff) begin
        d.byte_cnt = q.byte_cnt + 16'h0001;
      end
    end

    // condition vector
    // synchronised pins reset low, so serial loss shows for a few cycles
    // after reset; no indicator is assigned then, so nothing is counted
    cond[C_UNREC] = q.pin[P_PRESENT] & q.pin[P_DECODE_ERR];
    cond[C_SYNC_MISS] = q.sync_miss;
    cond[C_EXCESS] = q.pin[P_EXCESS];
    cond[C_SER_MISS] = ~q.pin[P_PRESENT];
    cond[C_OVERLAY] = q.pin[P_OVERLAY];
    d.cond_prev = cond;
    d.card_err = |(cond & q.en);

    // indicators and their occurrence counters
    for (int i = 0; i < 8; i++) begin
      hit = tsr_pick(cond, q.sel[i]);
      ev = hit & ~tsr_pick(q.cond_prev, q.sel[i]);
      d.ind[i] = hit ? q.pol[i] : ~q.pol[i];
      // a new occurrence in the clearing cycle survives as a count of one
      if (clr) begin
        d.cnt[i] = ev ? CNT_W'(1) : '0;
      end else if (ev && q.cnt[i] != {CNT_W{1'b1}}) begin
        d.cnt[i] = q.cnt[i] + CNT_W'(1);
      end
    end
  end

  // state register
  // settings take their package reset values; symbols start as fill, sync_miss and card_err start set; the rest clears to zero
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      q <= '0;
      q.mode <= tsr_mode_t'(MODE_RST);
      q.rate_hi <= RATE_RST;
      q.en <= ALARM_EN_RST;
      q.sel <= {8{IND_SEL_NONE}};
      q.pol <= IND_POL_RST;
      q.tx <= '{k: 1'b1, data: K28_5};
      q.jack <= '{k: 1'b1, data: K28_5};
      q.sync_miss <= 1'b1;
      q.card_err <= 1'b1;
      q.ind <= ~IND_POL_RST;
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state register
  // both alarm outputs carry the same enabled-condition summary
  assign reg_rdata = q.rdata;
  assign conv_sym = q.tx;
  assign jack_sym = q.jack;
  assign overlay_active = q.ovl;
  assign ref_rate_hi = q.rate_hi;
  assign card_err = q.card_err;
  assign net_alarm = q.card_err;
  assign ind_out = q.ind;
endmodule : tsr_repacker
`default_nettype wire

// ---- src/tsr_pkg.sv ----
`default_nettype none
package tsr_pkg;
  // register word offsets on the plain register port
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_ALARM_EN = 4'h1;
  localparam logic [3:0] OFS_IND_SEL = 4'h2;
  localparam logic [3:0] OFS_IND_POL = 4'h3;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_CNT_CLR = 4'h5;
  localparam logic [3:0] OFS_CNT_BASE = 4'h8;
  // field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_RATE_BIT = 2;
  localparam int STAT_HEALTH_BIT = 8;
  localparam int STAT_IND_LSB = 16;
  // values after reset
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic RATE_RST = 1'b0;
  localparam logic [4:0] ALARM_EN_RST = 5'h1f;
  localparam logic [2:0] IND_SEL_NONE = 3'h7;
  localparam logic [7:0] IND_POL_RST = 8'hff;
  // condition indices
  localparam int NCOND = 5;
  localparam int C_UNREC = 0;
  localparam int C_SYNC_MISS = 1;
  localparam int C_EXCESS = 2;
  localparam int C_SER_MISS = 3;
  localparam int C_OVERLAY = 4;
  // synchronised pin indices
  localparam int P_DECODE_ERR = 0;
  localparam int P_PRESENT = 1;
  localparam int P_EXCESS = 2;
  localparam int P_OVERLAY = 3;
  // packet lengths and fill symbol
  localparam logic [7:0] PAY_LEN = 8'hbc;
  localparam logic [7:0] LEN_188 = 8'hbc;
  localparam logic [7:0] LEN_204 = 8'hcc;
  localparam logic [7:0] LEN_208 = 8'hd0;
  localparam logic [7:0] K28_5 = 8'hbc;
  localparam logic [7:0] DUMMY_BYTE = 8'h00;
  // input rate check
  localparam int CLK_KHZ = 10000;
  localparam int RATE_LO_KBPS = 19390;
  localparam int RATE_HI_KBPS = 38780;
  localparam int RATE_WIN_US = 1000;
  localparam int RATE_WIN_CYC = RATE_WIN_US * CLK_KHZ / 1000;
  localparam int RATE_TOL_SHIFT = 4;

  typedef enum logic [1:0] {
    MODE_P188 = 2'b00,
    MODE_P204 = 2'b01,
    MODE_P208 = 2'b10,
    MODE_BYTE = 2'b11
  } tsr_mode_t;

  typedef enum logic {
    TX_IDLE = 1'b0,
    TX_SEND = 1'b1
  } tsr_tx_st_t;

  // one serial symbol: k flag plus byte
  typedef struct packed {
    logic k;
    logic [7:0] data;
  } tsr_sym_t;

  // transport-stream byte input
  typedef struct packed {
    logic valid;
    logic start;
    logic [7:0] data;
  } tsr_ts_t;

  // raw status pins from the serial side and front switch
  typedef struct packed {
    logic overlay_sw;
    logic rate_excess;
    logic present;
    logic decode_err;
  } tsr_pins_t;
endpackage : tsr_pkg
`default_nettype wire

// ---- src/tsr_pkt_mem.sv ----
`default_nettype none
module tsr_pkt_mem #(
  parameter int AW = 9,
  parameter int DW = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  // read port, data one cycle after the address
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // storage has no reset; only the read register does
  always_ff @(posedge ref_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // registered read
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata <= '0;
    end else begin
      rdata <= mem[raddr];
    end
  end
endmodule : tsr_pkt_mem
`default_nettype wire

// ---- dv/tsr_repacker_chk.sv ----
`default_nettype none
module tsr_repacker_chk
  import tsr_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // stream side
  input wire tsr_pkg::tsr_ts_t ts_in,
  input wire tsr_pkg::tsr_pins_t pins,
  input wire tsr_pkg::tsr_sym_t ovl_sym,
  input wire tsr_pkg::tsr_sym_t conv_sym,
  input wire tsr_pkg::tsr_sym_t jack_sym,
  // status outputs
  input wire logic overlay_active,
  input wire logic ref_rate_hi,
  input wire logic card_err,
  input wire logic net_alarm,
  input wire logic [7:0] ind_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [1:0] mode_q;
  logic rate_q;
  logic [4:0] en_q;
  logic [7:0] age_q;
  logic ok_q;
  logic [8:0] run_q;
  logic [8:0] len;
  logic ctrl_wr;
  assign ctrl_wr = reg_wr && reg_addr == OFS_CTRL;
  assign len = {1'b0, mode_q == MODE_P204 ? LEN_204 : mode_q == MODE_P208 ? LEN_208 : LEN_188};
  // settings shadow; age and ok skip the switchover, where a packet may be cut
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode_q <= MODE_RST;
      rate_q <= RATE_RST;
      en_q <= ALARM_EN_RST;
      age_q <= 8'h00;
      ok_q <= 1'b0;
      run_q <= 9'h000;
    end else begin
      if (ctrl_wr) begin
        mode_q <= reg_wdata[1:0];
        rate_q <= reg_wdata[CTRL_RATE_BIT];
      end
      if (reg_wr && reg_addr == OFS_ALARM_EN) begin
        en_q <= reg_wdata[4:0];
      end
      age_q <= ctrl_wr ? 8'h00 : age_q + {7'h00, age_q != 8'hff};
      ok_q <= ctrl_wr ? 1'b0 : ok_q | conv_sym.k;
      run_q <= (conv_sym.k || !ok_q) ? 9'h000 : run_q + 9'h001;
    end
  end
  sequence s_byte_steady;
    age_q == 8'hff && mode_q == MODE_BYTE;
  endsequence
  sequence s_serial_gone;
    !pins.present [*8];
  endsequence
  a_byte_forward: assert property (
    s_byte_steady ##0 ts_in.valid |=> conv_sym == {1'b0, $past(ts_in.data)})
    else $error("byte not forwarded next cycle");
  a_byte_fill: assert property (
    s_byte_steady ##0 !ts_in.valid |=> conv_sym == {1'b1, K28_5})
    else $error("fill missing while idle");
  a_packet_length: assert property (
    ok_q && mode_q != MODE_BYTE && conv_sym.k && run_q != 9'h000 |-> run_q == len)
    else $error("packet run length wrong");
  a_jack_path: assert property (
    !overlay_active [*3] |-> jack_sym == $past(conv_sym))
    else $error("jack not fed by converter");
  a_jack_overlay: assert property (
    overlay_active [*3] |-> jack_sym == $past(ovl_sym))
    else $error("jack not fed by overlay");
  a_overlay_on: assert property (
    pins.overlay_sw [*8] |-> overlay_active)
    else $error("overlay flag missing");
  a_overlay_off: assert property (
    !pins.overlay_sw [*8] |-> !overlay_active)
    else $error("overlay flag stuck");
  a_rate_shared: assert property (
    rate_q == $past(rate_q) |-> ref_rate_hi == rate_q)
    else $error("reference rate differs from setting");
  a_health_error: assert property (
    s_serial_gone ##0 (en_q[C_SER_MISS] && $past(en_q[C_SER_MISS])) |-> card_err)
    else $error("health not in error");
  a_mask_quiet: assert property (
    en_q == 5'h00 && $past(en_q) == 5'h00 |-> !card_err && !net_alarm)
    else $error("masked condition reached health");
endmodule  // tsr_repacker_chk
`default_nettype wire

// ---- dv/tsr_ts_src.sv ----
`default_nettype none
module tsr_ts_src
  import tsr_pkg::*;
(
  // clock
  input wire logic ref_clk,
  // pacing from the bench
  input wire logic en,
  input wire logic rate_hi,
  // byte stream
  output tsr_pkg::tsr_ts_t ts
);
  timeunit 1ns;
  timeprecision 1ns;
  int acc = 0;
  int idx = 0;
  initial ts = '0;
  // accumulator pacing gives the mean byte rate; idle data toggles, never holds
  always @(posedge ref_clk) begin
    if (!en) begin
      ts <= {2'b00, ~ts.data};
    end else begin
      acc = acc + (rate_hi ? 97 : 48);
      if (acc >= 200) begin
        acc = acc - 200;
        ts <= {1'b1, idx == 0, 8'(idx)};
        idx = (idx + 1) % 188;
      end else begin
        ts <= {2'b00, ~ts.data};
      end
    end
  end
endmodule  // tsr_ts_src
`default_nettype wire

// ---- dv/tsr_repacker_tb_top.sv ----
`default_nettype none
module tsr_repacker_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import tsr_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  tsr_ts_t ts_in;
  tsr_pins_t pins = 4'b0010;
  tsr_sym_t ovl_sym = 9'h000;
  tsr_sym_t conv_sym;
  tsr_sym_t jack_sym;
  logic overlay_active, ref_rate_hi, card_err, net_alarm;
  logic [7:0] ind_out;
  logic src_en = 1'b0;
  logic src_hi = 1'b0;
  int miscompares = 0;
  int total_checks = 0;
  tsr_pins_t pin_tab [4] = '{4'b0011, 4'b0000, 4'b0110, 4'b1010};
  logic [31:0] cond_tab [4] = '{32'h1, 32'h8, 32'h4, 32'h10};
  int len_tab [3] = '{188, 204, 208};
  // clock and a changing overlay picture
  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) ovl_sym.data <= ovl_sym.data + 8'h01;
  tsr_ts_src u_tsr_ts_src (.ref_clk, .en(src_en), .rate_hi(src_hi), .ts(ts_in));
  tsr_repacker #(.WIN_CYC(200)) u_tsr_repacker (.ref_clk, .rst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .ts_in, .pins, .ovl_sym, .conv_sym, .jack_sym,
    .overlay_active, .ref_rate_hi, .card_err, .net_alarm, .ind_out);
  task automatic chk_reg(string what, logic [31:0] e, logic [31:0] a);
    total_checks++;
    if (a !== e) begin
      miscompares++;
      $display("mismatch %s exp %h got %h", what, e, a);
    end
  endtask
  task automatic chk_sym(tsr_sym_t e, tsr_sym_t a);
    total_checks++;
    if (a !== e) begin
      miscompares++;
      $display("mismatch conv_sym exp %h got %h", e, a);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(logic [3:0] a, logic [31:0] m, logic [31:0] e, string what);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk_reg(what, e, reg_rdata & m);
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wait_k(logic v);
    int n;
    n = 0;
    while (conv_sym.k !== v && n < 3000) begin
      @(posedge ref_clk);
      #1 n++;
    end
    chk_reg("boundary wait", 32'h0, {31'h0, n == 3000});
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // a hang ends the run through the same closing task
  initial begin
    repeat (40000) @(posedge ref_clk);
    miscompares++;
    complete_run();
  end
  initial begin
    tsr_ts_t t;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    rd(OFS_CTRL, 32'hffffffff, 32'h0, "ctrl");
    rd(OFS_ALARM_EN, 32'hffffffff, 32'h1f, "alarm_en");
    rd(OFS_IND_SEL, 32'hffffffff, 32'hffffff, "ind_sel");
    rd(OFS_IND_POL, 32'hffffffff, 32'hff, "ind_pol");
    rd(4'h6, 32'hffffffff, 32'h0, "unmapped");
    chk_reg("ind_out", 32'h0, {24'h0, ind_out});
    chk_reg("card_err", 32'h1, {31'h0, card_err});
    // rate setting against the sync stream, both rates
    src_en <= 1'b1;
    cyc(700);
    rd(OFS_STATUS, 32'hffffffff, 32'h0, "status");
    wr(OFS_CTRL, 32'h4);
    cyc(500);
    rd(OFS_STATUS, 32'h2, 32'h2, "sync_miss");
    chk_reg("ref_rate_hi", 32'h1, {31'h0, ref_rate_hi});
    src_hi <= 1'b1;
    cyc(500);
    rd(OFS_STATUS, 32'h2, 32'h0, "sync_miss");
    wr(OFS_CTRL, 32'h0);
    src_hi <= 1'b0;
    cyc(500);
    // each pin-driven condition alone
    for (int i = 0; i < 4; i++) begin
      pins <= pin_tab[i];
      cyc(10);
      rd(OFS_STATUS, 32'h1f, cond_tab[i], "conditions");
      chk_reg("overlay", {31'h0, i == 3}, {31'h0, overlay_active});
    end
    pins <= 4'b0010;
    // indicators 0 and 1 on serial loss, one active high, one active low
    wr(OFS_IND_SEL, 32'hffffdb);
    wr(OFS_IND_POL, 32'hfd);
    cyc(10);
    chk_reg("ind_out", 32'h2, {24'h0, ind_out});
    for (int i = 0; i < 2; i++) begin
      pins <= 4'b0000;
      cyc(10);
      chk_reg("ind_out", 32'h1, {24'h0, ind_out});
      chk_reg("card_err", 32'h1, {31'h0, card_err});
      pins <= 4'b0010;
      cyc(10);
    end
    rd(OFS_CNT_BASE, 32'hffff, 32'h2, "count0");
    rd(OFS_CNT_BASE + 4'h1, 32'hffff, 32'h2, "count1");
    rd(OFS_CNT_BASE + 4'h2, 32'hffff, 32'h0, "count2");
    wr(OFS_CNT_CLR, 32'h1);
    rd(OFS_CNT_BASE, 32'hffff, 32'h0, "count0");
    // mask off everything, then only serial loss
    wr(OFS_ALARM_EN, 32'h0);
    pins <= 4'b0000;
    cyc(10);
    rd(OFS_STATUS, 32'h100, 32'h0, "health");
    wr(OFS_ALARM_EN, 32'h8);
    cyc(3);
    chk_reg("net_alarm", 32'h1, {31'h0, net_alarm});
    pins <= 4'b0010;
    wr(OFS_ALARM_EN, 32'h1f);
    // immediate forward, every cycle compared
    wr(OFS_CTRL, 32'h3);
    cyc(300);
    for (int i = 0; i < 400; i++) begin
      @(posedge ref_clk);
      t = ts_in;
      #1 chk_sym(t.valid ? {1'b0, t.data} : {1'b1, K28_5}, conv_sym);
    end
    // whole packets of each length, then one fill
    for (int m = 0; m < 3; m++) begin
      wr(OFS_CTRL, 32'(m));
      cyc(1000);
      wait_k(1'b1);
      wait_k(1'b0);
      for (int i = 0; i <= len_tab[m]; i++) begin
        chk_sym(i < 188 ? {1'b0, 8'(i)} : i < len_tab[m] ? {1'b0, DUMMY_BYTE}
          : {1'b1, K28_5}, conv_sym);
        cyc(1);
      end
    end
    complete_run();
  end
endmodule  // tsr_repacker_tb_top
bind tsr_repacker tsr_repacker_chk u_tsr_repacker_chk (.ref_clk, .rst, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ts_in, .pins, .ovl_sym, .conv_sym,
  .jack_sym, .overlay_active, .ref_rate_hi, .card_err, .net_alarm, .ind_out);
`default_nettype wire
